// ===== rtl/hss_hot_swap_seq.v
// Control logic of a hot-swap power switch: turn-on sequencing, power-good,
// fault turn-off, circuit breaker, cooldown, latch-off and retry.
// Assumes all analog results arrive as digitised comparator levels from
// outside the clock domain, and a classic Wishbone master on mclk.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "hss_defs.vh"

// Summary of operation
// R01 - Start sequencing only after main supply and internal rail are both valid.
// R02 - A power-on pulse clears the fault register and all internal latches.
// R03 - Turn on only after both input comparators stay good for the qualification time; exits from ST_HOLD and ST_COOL turn on without it.
// R04 - Release power-good only with feedback high and gate drive above trip level.
// R05 - Input falling below its low threshold turns the switch off normally.
// R06 - Overvoltage, circuit-breaker timeout or overtemperature also turn it off.
// R07 - Once off and feedback has fallen, power-good is pulled low; code pulls it low at switch-off without waiting for feedback.
// R08 - Fast shutdown on supply low over 5 us or rail low over 1 us.
// R09 - Overcurrent fault only after current limiting lasts past the breaker timeout.
// R10 - Run the breaker timer while limiting; trip on timer upper comparator.
// R11 - Timer strapped to rail selects a fixed internal 2 ms breaker delay.
// R12 - Any overcurrent turn-off asserts the active-low fault output.
// R13 - After overcurrent trip, start cooldown once timer reports discharged level.
// R14 - After cooldown, turn on again only if the fault latch is cleared.
// R15 - Input held below reset level at least 1 us, then high, clears latch.
// R16 - Strapped timer still waits the internal cooldown, then needs a cleared latch.
// R17 - Fault output wired to low input gives self-clear and periodic retry.
// R18 - Auto-retry works the same with the strapped internal delays.
// R19 - Without a retry the switch stays latched off after an overcurrent.
// R20 - Keep the switch off while the overtemperature indication is set.
// R21 - All delays are clock counters; qualification restarts when any condition drops. The unstrapped breaker delay uses the timer pin comparator instead.
module hss_hot_swap_seq #(
  parameter [31:0] POR_CYCLES = `HSS_POR_CYC,
  parameter [31:0] QUAL_CYCLES = `HSS_QUAL_CYC,
  parameter [31:0] CB_CYCLES = `HSS_CB_CYC,
  parameter [31:0] COOL_CYCLES = `HSS_COOL_CYC
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire supplyOk,
  input wire railOk,
  input wire inputTooLow,
  input wire uvResetLevel,
  input wire inputTooHigh,
  input wire outputFeedback,
  input wire gateDriveHigh,
  input wire currentLimit,
  input wire timerHigh,
  input wire timerLow,
  input wire timerStrapped,
  input wire overTemp,
  input wire powerOkOutIn,
  output wire powerOkOut,
  output reg powerOkOutOe_n,
  input wire faultOutIn_n,
  output wire faultOut_n,
  output reg faultOutOe_n,
  output reg switchOn,
  output reg fastShutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // States and fixed counts
  localparam [2:0] ST_LOCK = 3'h0;
  localparam [2:0] ST_POR = 3'h1;
  localparam [2:0] ST_QUAL = 3'h2;
  localparam [2:0] ST_ON = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_TRIP = 3'h5;
  localparam [2:0] ST_COOL = 3'h6;
  localparam [31:0] SUPPLY_LIM = `HSS_SUPPLY_CYC;
  localparam [31:0] RAIL_LIM = `HSS_RAIL_CYC;
  localparam [31:0] UVRST_LIM = `HSS_UVRST_CYC;

  // Register index decode, shared by read and write paths
  function [1:0] regIndex;
    input [7:0] adr;
    begin
      if ({adr[7:2], 2'b00} == `HSS_REG_CTRL) begin
        regIndex = 2'h1;
      end else if ({adr[7:2], 2'b00} == `HSS_REG_STATUS) begin
        regIndex = 2'h2;
      end else if ({adr[7:2], 2'b00} == `HSS_REG_EVENT) begin
        regIndex = 2'h3;
      end else begin
        regIndex = 2'h0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  wire [`HSS_NIN-1:0] rawIn;
  reg [`HSS_NIN-1:0] syncMeta;
  reg [`HSS_NIN-1:0] syncIn;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] seqCount;
  reg [31:0] next_seqCount;
  reg [31:0] supplyLowCount;
  reg [31:0] railLowCount;
  reg [31:0] uvLowCount;
  reg faultLatch;
  reg ctrlEnable;
  reg [`HSS_EV_W-1:0] eventFlags;
  reg [`HSS_EV_W-1:0] evSet;
  reg ocTrip;
  wire supOk;
  wire rlOk;
  wire inLow;
  wire uvRst;
  wire inHigh;
  wire fbHigh;
  wire gateHigh;
  wire iLim;
  wire tmrHigh;
  wire tmrLow;
  wire strap;
  wire oTemp;
  wire fastTrip;
  wire uvArmed;
  wire uvClear;
  wire enableOk;
  wire busReq;
  wire busWrite;
  wire [1:0] busIdx;
  wire [`HSS_EV_W-1:0] evClear;
  reg [31:0] readMux;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; every comparator is asynchronous to mclk
  assign rawIn = {powerOkOutIn, faultOutIn_n, overTemp, timerStrapped,
                  timerLow, timerHigh, currentLimit, gateDriveHigh,
                  outputFeedback, inputTooHigh, uvResetLevel, inputTooLow,
                  railOk, supplyOk};

  always @(posedge mclk) begin
    if (!rst_b) begin
      syncMeta <= {`HSS_NIN{1'b0}};
      syncIn <= {`HSS_NIN{1'b0}};
    end else if (ce) begin
      syncMeta <= rawIn;
      syncIn <= syncMeta;
    end
  end

  // Named views of the second stage only
  assign supOk = syncIn[`HSS_IN_SUPPLY];
  assign rlOk = syncIn[`HSS_IN_RAIL];
  assign inLow = syncIn[`HSS_IN_LOW];
  assign uvRst = syncIn[`HSS_IN_UVRST];
  assign inHigh = syncIn[`HSS_IN_HIGH];
  assign fbHigh = syncIn[`HSS_IN_FB];
  assign gateHigh = syncIn[`HSS_IN_GATE];
  assign iLim = syncIn[`HSS_IN_ILIM];
  assign tmrHigh = syncIn[`HSS_IN_TMRHI];
  assign tmrLow = syncIn[`HSS_IN_TMRLO];
  assign strap = syncIn[`HSS_IN_STRAP];
  assign oTemp = syncIn[`HSS_IN_OTEMP];

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filters for supply collapse; short dips are ridden out
  always @(posedge mclk) begin
    if (!rst_b) begin
      supplyLowCount <= 32'h00000000;
      railLowCount <= 32'h00000000;
    end else if (ce) begin
      if (supOk) begin
        supplyLowCount <= 32'h00000000;
      end else if (supplyLowCount != SUPPLY_LIM) begin
        supplyLowCount <= supplyLowCount + 32'h00000001; // see R08
      end
      if (rlOk) begin
        railLowCount <= 32'h00000000;
      end else if (railLowCount != RAIL_LIM) begin
        railLowCount <= railLowCount + 32'h00000001; // see R08
      end
    end
  end

  // Level stays up while either supply is still low
  assign fastTrip = (supplyLowCount == SUPPLY_LIM) | (railLowCount == RAIL_LIM); // see R08

  ////////////////////////////////////////////////////////////////////////////
  // Latch clear detector: low for the minimum time, then back high
  always @(posedge mclk) begin
    if (!rst_b) begin
      uvLowCount <= 32'h00000000;
    end else if (ce) begin
      if (uvClear) begin
        uvLowCount <= 32'h00000000;
      end else if (uvRst) begin
        if (!uvArmed) begin
          uvLowCount <= uvLowCount + 32'h00000001; // see R15
        end
      end else if (!uvArmed) begin
        uvLowCount <= 32'h00000000; // Too short a dip is forgotten
      end
    end
  end

  assign uvArmed = (uvLowCount == UVRST_LIM);
  // The return must clear the low threshold, not merely the reset level
  assign uvClear = uvArmed & !uvRst & !inLow; // see R15

  // Turn-on conditions that qualification watches, apart from the fault latch
  assign enableOk = !inLow & !inHigh & !oTemp & ctrlEnable; // see R03

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next-state logic
  always @* begin
    next_state = state;
    next_seqCount = seqCount;
    ocTrip = 1'b0;
    evSet = {`HSS_EV_W{1'b0}};
    case (state)
      ST_LOCK: begin
        next_seqCount = 32'h00000000;
        if (supOk & rlOk) begin
          next_state = ST_POR; // see R01
        end
      end
      ST_POR: begin
        if (seqCount >= POR_CYCLES - 32'h00000001) begin
          next_state = ST_QUAL;
          next_seqCount = 32'h00000000;
        end else begin
          next_seqCount = seqCount + 32'h00000001; // see R02
        end
      end
      ST_QUAL: begin
        if (!enableOk | faultLatch) begin
          next_seqCount = 32'h00000000; // see R21
        end else if (seqCount >= QUAL_CYCLES - 32'h00000001) begin
          next_state = ST_ON; // see R03
          next_seqCount = 32'h00000000;
        end else begin
          next_seqCount = seqCount + 32'h00000001;
        end
      end
      ST_ON: begin
        if (inHigh | oTemp) begin
          next_state = ST_HOLD; // see R06
          next_seqCount = 32'h00000000;
          evSet[`HSS_EV_OV] = inHigh;
          evSet[`HSS_EV_OT] = oTemp;
        end else if (inLow | !ctrlEnable) begin
          next_state = ST_QUAL; // see R05
          next_seqCount = 32'h00000000;
          evSet[`HSS_EV_UV] = inLow;
        end else if (iLim) begin
          // Strapped timer counts internally, otherwise the pin comparator
          if (strap ? (seqCount >= CB_CYCLES - 32'h00000001) : tmrHigh) begin
            ocTrip = 1'b1; // see R09, R10, R11
            next_state = ST_TRIP;
            next_seqCount = 32'h00000000;
            evSet[`HSS_EV_OC] = 1'b1;
          end else begin
            next_seqCount = seqCount + 32'h00000001; // see R10
          end
        end else begin
          next_seqCount = 32'h00000000; // Limiting must be continuous
        end
      end
      ST_HOLD: begin
        next_seqCount = 32'h00000000;
        if (!inHigh & !oTemp) begin
          // Overvoltage recovery turns on at once, no requalification
          next_state = (!inLow & ctrlEnable) ? ST_ON : ST_QUAL; // see R20
        end
      end
      ST_TRIP: begin
        next_seqCount = 32'h00000000;
        if (strap | tmrLow) begin
          next_state = ST_COOL; // see R13, R16
        end
      end
      ST_COOL: begin
        if (seqCount < COOL_CYCLES) begin
          next_seqCount = seqCount + 32'h00000001; // see R13
        end else if (!faultLatch) begin
          // Retry only once the latch is gone; else stay off
          next_state = enableOk ? ST_ON : ST_QUAL; // see R14, R17, R18, R19
        end
      end
      default: begin
        next_state = ST_LOCK;
        next_seqCount = 32'h00000000;
      end
    endcase
    // Supply collapse overrides the next state and count and restarts from lockout; a breaker trip in the same cycle still latches
    if (fastTrip) begin
      next_state = ST_LOCK; // see R08
      next_seqCount = 32'h00000000;
      evSet[`HSS_EV_FAST] = !fastShutdown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state, fault latch and pin drivers
  always @(posedge mclk) begin
    if (!rst_b) begin
      state <= ST_LOCK;
      seqCount <= 32'h00000000;
      faultLatch <= 1'b0;
      switchOn <= 1'b0;
      fastShutdown <= 1'b0;
      powerOkOutOe_n <= 1'b0;
      faultOutOe_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      seqCount <= next_seqCount;
      // A trip in the clearing cycle still latches
      if (ocTrip) begin
        faultLatch <= 1'b1; // see R12
      end else if (uvClear | (state == ST_POR)) begin
        faultLatch <= 1'b0; // see R02, R15
      end
      switchOn <= (next_state == ST_ON); // see R05, R06, R20
      fastShutdown <= fastTrip; // see R08
      // Pull-down while not on or output not yet good
      powerOkOutOe_n <= (next_state == ST_ON) & fbHigh & gateHigh; // see R04, R07
      // Wire lets go once the low time is met, else a looped-back wire never returns high
      faultOutOe_n <= !(ocTrip | (faultLatch & !uvArmed)); // see R12, R17
    end
  end

  // Open-drain pins only ever pull low
  assign powerOkOut = 1'b0;
  assign faultOut_n = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for any address
  assign busReq = wb_cyc_i & wb_stb_i & !wb_ack_o;
  assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign busIdx = regIndex(wb_adr_i);
  assign evClear = (busWrite & wb_sel_i[0] & (busIdx == 2'h3)) ?
                   wb_dat_i[`HSS_EV_W-1:0] : {`HSS_EV_W{1'b0}};

  // Read view; unmapped words read as zero
  always @* begin
    readMux = 32'h00000000;
    case (busIdx)
      2'h1: readMux[`HSS_CTRL_EN_BIT] = ctrlEnable;
      2'h2: readMux = {9'h000, syncIn, 1'b0, strap, fastShutdown,
                       powerOkOutOe_n, faultLatch, switchOn, state};
      2'h3: readMux[`HSS_EV_W-1:0] = eventFlags;
      default: readMux = 32'h00000000;
    endcase
  end

  // Write lands on the acknowledging edge
  always @(posedge mclk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrlEnable <= `HSS_CTRL_RESET;
      eventFlags <= {`HSS_EV_W{1'b0}};
    end else if (ce) begin
      wb_ack_o <= busReq;
      if (busReq) begin
        wb_dat_o <= readMux;
      end
      if (busWrite & wb_sel_i[0] & (busIdx == 2'h1)) begin
        ctrlEnable <= wb_dat_i[`HSS_CTRL_EN_BIT];
      end
      // New events win over a clear in the same cycle
      if (state == ST_POR) begin
        eventFlags <= evSet; // see R02
      end else begin
        eventFlags <= (eventFlags & ~evClear) | evSet;
      end
    end
  end

endmodule // hss_hot_swap_seq

// ===== rtl/hss_defs.vh
// Constants of the hot-swap switch sequencer: register map, field positions,
// reset values and timing counts. Assumes a 200 MHz logic clock.
`ifndef HSS_DEFS_VH
`define HSS_DEFS_VH
// Register byte offsets
`define HSS_REG_CTRL 8'h00
`define HSS_REG_STATUS 8'h04
`define HSS_REG_EVENT 8'h08
// Control register
`define HSS_CTRL_RESET 1'b1
`define HSS_CTRL_EN_BIT 0
// Sticky event bits
`define HSS_EV_UV 0
`define HSS_EV_OV 1
`define HSS_EV_OC 2
`define HSS_EV_OT 3
`define HSS_EV_FAST 4
`define HSS_EV_W 5
// Positions of comparator inputs in the synchroniser bus
`define HSS_IN_SUPPLY 0
`define HSS_IN_RAIL 1
`define HSS_IN_LOW 2
`define HSS_IN_UVRST 3
`define HSS_IN_HIGH 4
`define HSS_IN_FB 5
`define HSS_IN_GATE 6
`define HSS_IN_ILIM 7
`define HSS_IN_TMRHI 8
`define HSS_IN_TMRLO 9
`define HSS_IN_STRAP 10
`define HSS_IN_OTEMP 11
`define HSS_IN_FLT 12
`define HSS_IN_PG 13
`define HSS_NIN 14
// Clock and times in their printed units
`define HSS_CLK_PERIOD_PS 5000
`define HSS_CYC_PER_US (1000000 / `HSS_CLK_PERIOD_PS)
`define HSS_T_POR_US 25
`define HSS_T_QUAL_MS 100
`define HSS_T_SUPPLY_US 5
`define HSS_T_RAIL_US 1
`define HSS_T_UVRST_US 1
`define HSS_T_CB_MS 2
`define HSS_T_COOL_MS 100
// Derived cycle counts
`define HSS_POR_CYC (`HSS_T_POR_US * `HSS_CYC_PER_US)
`define HSS_QUAL_CYC (`HSS_T_QUAL_MS * 1000 * `HSS_CYC_PER_US)
`define HSS_SUPPLY_CYC (`HSS_T_SUPPLY_US * `HSS_CYC_PER_US)
`define HSS_RAIL_CYC (`HSS_T_RAIL_US * `HSS_CYC_PER_US)
`define HSS_UVRST_CYC (`HSS_T_UVRST_US * `HSS_CYC_PER_US)
`define HSS_CB_CYC (`HSS_T_CB_MS * 1000 * `HSS_CYC_PER_US)
`define HSS_COOL_CYC (`HSS_T_COOL_MS * 1000 * `HSS_CYC_PER_US)
`endif

// ===== testbench/hss_card_model.sv
// Card and backplane model: comparator levels seen by the sequencer.
// Assumes open-drain fault and power-good wires with pull-ups.
`timescale 1ns/1ps
module hss_card_model (
  input wire mclk,
  input wire switchOn,
  input wire powerOkOut,
  input wire powerOkOutOe_n,
  input wire faultOut_n,
  input wire faultOutOe_n,
  input wire shortLoad,
  input wire uvLow,
  input wire uvReset,
  input wire autoRetry,
  output wire inputTooLow,
  output wire uvResetLevel,
  output wire outputFeedback,
  output wire gateDriveHigh,
  output wire currentLimit,
  output wire timerHigh,
  output wire timerLow,
  output wire powerOkOutIn,
  output wire faultOutIn_n
);
  logic [1:0] ramp = 2'h0;
  logic limiting = 1'b0;
  logic [3:0] tmr = 4'h0;
  wire uvPulled;
  ////////////////////////////////////////////////////////////////////////////
  // Released wires float to the pull-up level
  assign faultOutIn_n = faultOutOe_n ? 1'b1 : faultOut_n;
  assign powerOkOutIn = powerOkOutOe_n ? 1'b1 : powerOkOut;
  // Fault wire strapped to the low-input pin gives self-clearing retry
  assign uvPulled = autoRetry && !faultOutIn_n;
  assign inputTooLow = uvLow || uvReset || uvPulled;
  assign uvResetLevel = uvReset || uvPulled;
  assign outputFeedback = ramp[1];
  assign gateDriveHigh = ramp[1];
  assign currentLimit = limiting;
  assign timerHigh = tmr >= 4'h8;
  assign timerLow = tmr == 4'h0;
  // Output lags the gate; timer ramps only while limiting, so a short trips
  always @(posedge mclk) begin
    ramp <= {ramp[0], switchOn};
    limiting <= switchOn && shortLoad;
    if (limiting && tmr != 4'hF) begin
      tmr <= tmr + 4'h1;
    end else if (!limiting && tmr != 4'h0) begin
      tmr <= tmr - 4'h1;
    end
  end
endmodule // hss_card_model

// ===== testbench/hss_seq_chk_sva.sv
// Port checker of the hot-swap sequencer.
// Assumes a bind onto the sequencer top with ce held high.
`timescale 1ns/1ps
module hss_seq_chk #(
  parameter [31:0] CB_CYCLES = 20
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire supplyOk,
  input wire railOk,
  input wire inputTooHigh,
  input wire overTemp,
  input wire currentLimit,
  input wire timerStrapped,
  input wire powerOkOutOe_n,
  input wire faultOutOe_n,
  input wire switchOn,
  input wire fastShutdown
);
  int lowCnt = 0;
  int railCnt = 0;
  int limCnt = 0;
  default clocking chkClk @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Run lengths of supply loss and limiting; margins cover the synchronisers
  always @(posedge mclk) begin
    lowCnt <= (!rst_b || supplyOk) ? 0 : lowCnt + 1;
    railCnt <= (!rst_b || railOk) ? 0 : railCnt + 1;
    limCnt <= (!rst_b || !currentLimit) ? 0 : limCnt + 1;
  end
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence ovHeld;
    inputTooHigh [*5];
  endsequence
  sequence otHeld;
    overTemp [*5];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_latency_a: assert property (busReq |=> wb_ack_o) else $error("ack late");
  pg_needs_on_a: assert property (powerOkOutOe_n |-> switchOn)
    else $error("power good with switch off");
  flt_means_off_a: assert property (!faultOutOe_n |-> !switchOn)
    else $error("fault with switch on");
  fast_off_a: assert property (fastShutdown |-> !switchOn)
    else $error("fast shutdown with switch on");
  ov_off_a: assert property (ovHeld |-> !switchOn) else $error("on in overvoltage");
  ot_off_a: assert property (otHeld |-> !switchOn) else $error("on in overtemp");
  collapse_trip_a: assert property ((lowCnt == 1010 || railCnt == 210) |-> fastShutdown)
    else $error("no fast shutdown");
  cb_bound_a: assert property (switchOn && timerStrapped |-> limCnt <= CB_CYCLES + 4)
    else $error("breaker late");
  cb_early_a: assert property ($fell(faultOutOe_n) && timerStrapped |-> limCnt >= CB_CYCLES)
    else $error("breaker early");
endmodule // hss_seq_chk
bind hss_hot_swap_seq hss_seq_chk #(.CB_CYCLES(CB_CYCLES)) chk (
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .supplyOk(supplyOk), .railOk(railOk), .inputTooHigh(inputTooHigh),
  .overTemp(overTemp), .currentLimit(currentLimit), .timerStrapped(timerStrapped),
  .powerOkOutOe_n(powerOkOutOe_n), .faultOutOe_n(faultOutOe_n), .switchOn(switchOn),
  .fastShutdown(fastShutdown));

// ===== testbench/tb.sv
// Bench of the hot-swap sequencer: Wishbone tasks and comparator stimulus.
// Assumes the card model and the bound port checker.
`timescale 1ns/1ps
module tb;
  localparam int QUAL = 50;
  localparam int CB = 20;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datI = 32'h0;
  logic supplyOk = 1'b1;
  logic railOk = 1'b1;
  logic inputTooHigh = 1'b0;
  logic overTemp = 1'b0;
  logic timerStrapped = 1'b1;
  logic shortLoad = 1'b0;
  logic uvLow = 1'b0;
  logic uvReset = 1'b0;
  logic autoRetry = 1'b0;
  wire [31:0] datO;
  wire ack, inputTooLow, uvResetLevel, outputFeedback, gateDriveHigh, currentLimit;
  wire timerHigh, timerLow, powerOkOutIn, powerOkOut, powerOkOutOe_n;
  wire faultOutIn_n, faultOut_n, faultOutOe_n, switchOn, fastShutdown;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  logic [31:0] q;
  initial forever #2.5 mclk = ~mclk;
  // Short delays keep the run brief
  hss_hot_swap_seq #(.POR_CYCLES(10), .QUAL_CYCLES(QUAL), .CB_CYCLES(CB), .COOL_CYCLES(30)) dut (
    .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .supplyOk(supplyOk), .railOk(railOk), .inputTooLow(inputTooLow),
    .uvResetLevel(uvResetLevel), .inputTooHigh(inputTooHigh), .outputFeedback(outputFeedback),
    .gateDriveHigh(gateDriveHigh), .currentLimit(currentLimit), .timerHigh(timerHigh),
    .timerLow(timerLow), .timerStrapped(timerStrapped), .overTemp(overTemp),
    .powerOkOutIn(powerOkOutIn), .powerOkOut(powerOkOut), .powerOkOutOe_n(powerOkOutOe_n),
    .faultOutIn_n(faultOutIn_n), .faultOut_n(faultOut_n), .faultOutOe_n(faultOutOe_n),
    .switchOn(switchOn), .fastShutdown(fastShutdown));
  hss_card_model card (
    .mclk(mclk), .switchOn(switchOn), .powerOkOut(powerOkOut),
    .powerOkOutOe_n(powerOkOutOe_n), .faultOut_n(faultOut_n), .faultOutOe_n(faultOutOe_n),
    .shortLoad(shortLoad), .uvLow(uvLow), .uvReset(uvReset), .autoRetry(autoRetry),
    .inputTooLow(inputTooLow), .uvResetLevel(uvResetLevel), .outputFeedback(outputFeedback),
    .gateDriveHigh(gateDriveHigh), .currentLimit(currentLimit), .timerHigh(timerHigh),
    .timerLow(timerLow), .powerOkOutIn(powerOkOutIn), .faultOutIn_n(faultOutIn_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic lose(input string nm);
    n_mismatch++;
    $display("[ERR] %s expected answer seen timeout", nm);
    tally_and_finish();
  endtask
  // Classic cycle: request held until ack is sampled, then dropped
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      lose("ack");
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Bounded wait for the switch; n returns the cycles taken
  task automatic wsw(input logic v, input int lim);
    n = 0;
    while (switchOn !== v) begin
      @(posedge mclk);
      n++;
      if (n > lim) begin
        lose("switchOn");
      end
    end
  endtask
  task automatic uvToggle(input int len);
    @(posedge mclk);
    uvReset <= 1'b1;
    repeat (len) @(posedge mclk);
    uvReset <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task automatic ocTrip(input logic strap, input int minCyc);
    timerStrapped <= strap;
    shortLoad <= 1'b1;
    wsw(1'b0, 2000);
    chk("trip delay", 32'h1, {31'h0, n >= minCyc});
    repeat (3) @(posedge mclk);
    chk("fault oe", 32'h0, {31'h0, faultOutOe_n});
    shortLoad <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    chk("power ok oe", 32'h0, {31'h0, powerOkOutOe_n});
    chk("fault oe", 32'h1, {31'h0, faultOutOe_n});
    chk("open drain levels", 32'h0, {30'h0, powerOkOut, faultOut_n});
    rdc(8'h00, 32'h1);
    bus(1'b1, 8'h0C, 32'hFFFFFFFF);
    rdc(8'h0C, 32'h0);
    rdc(8'h08, 32'h0);
    // Bounce during qualification restarts the count; let qualification start first
    repeat (20) @(posedge mclk);
    inputTooHigh <= 1'b1;
    repeat (2) @(posedge mclk);
    inputTooHigh <= 1'b0;
    wsw(1'b1, 500);
    chk("qual length", 32'h1, {31'h0, n >= QUAL});
    repeat (6) @(posedge mclk);
    chk("power ok oe", 32'h1, {31'h0, powerOkOutOe_n});
    bus(1'b0, 8'h04, 32'h0);
    chk("status", 32'h2B, q & 32'h3F);
    $display("test turn_on finished");
    uvLow <= 1'b1;
    wsw(1'b0, 20);
    repeat (8) @(posedge mclk);
    chk("power ok oe", 32'h0, {31'h0, powerOkOutOe_n});
    rdc(8'h08, 32'h1);
    bus(1'b1, 8'h08, 32'h1F);
    rdc(8'h08, 32'h0);
    uvLow <= 1'b0;
    wsw(1'b1, 500);
    // Overvoltage then overtemperature
    for (int i = 0; i < 2; i++) begin
      inputTooHigh <= (i == 0);
      overTemp <= (i == 1);
      wsw(1'b0, 20);
      rdc(8'h08, (i == 0) ? 32'h2 : 32'h8);
      inputTooHigh <= 1'b0;
      overTemp <= 1'b0;
      bus(1'b1, 8'h08, 32'h1F);
      wsw(1'b1, 500);
    end
    bus(1'b1, 8'h00, 32'h0);
    wsw(1'b0, 20);
    rdc(8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    wsw(1'b1, 500);
    $display("test turn_off finished");
    ocTrip(1'b1, CB);
    repeat (80) @(posedge mclk);
    chk("latched off", 32'h0, {31'h0, switchOn});
    rdc(8'h08, 32'h4);
    uvToggle(100);
    chk("fault oe", 32'h0, {31'h0, faultOutOe_n});
    uvToggle(250);
    chk("fault oe", 32'h1, {31'h0, faultOutOe_n});
    wsw(1'b1, 500);
    ocTrip(1'b0, 8);
    uvToggle(250);
    wsw(1'b1, 500);
    bus(1'b1, 8'h08, 32'h1F);
    $display("test overcurrent finished");
    supplyOk <= 1'b0;
    repeat (1100) @(posedge mclk);
    chk("fast shutdown", 32'h1, {31'h0, fastShutdown});
    supplyOk <= 1'b1;
    wsw(1'b1, 500);
    rdc(8'h08, 32'h0);
    railOk <= 1'b0;
    repeat (300) @(posedge mclk);
    chk("fast shutdown", 32'h1, {31'h0, fastShutdown});
    railOk <= 1'b1;
    wsw(1'b1, 500);
    $display("test collapse finished");
    autoRetry <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      timerStrapped <= (s == 1);
      shortLoad <= 1'b1;
      wsw(1'b0, 3000);
      wsw(1'b1, 3000);
      wsw(1'b0, 3000);
      shortLoad <= 1'b0;
      wsw(1'b1, 3000);
    end
    $display("test retry finished");
    tally_and_finish();
  end
endmodule // tb
